// ==== core/prs_pkg.sv ====
// Constants and types for the power-on reset sequencer.
// Assumes a single 25 MHz system clock; no software-visible registers.
package prs_pkg;

    // Clock rate in kHz
    localparam int CLK_KHZ = 25000;

    // Times in their own units
    localparam int POR_EXT_US = 30; // power_on_extension_time, longest
    localparam int BROWNOUT_EXT_US = 100; // brownout_extension_time, longest
    localparam int FSCM_US = 900; // clock_fail_detect_delay, longest
    localparam int PUD_MAX_MS = 128; // power_up_delay_time, top setting

    // Cycle counts; longest times round down
    localparam int POR_EXT_CYC = POR_EXT_US * CLK_KHZ / 1000;
    localparam int BROWNOUT_EXT_CYC = BROWNOUT_EXT_US * CLK_KHZ / 1000;
    localparam int FSCM_CYC = FSCM_US * CLK_KHZ / 1000;
    localparam int PUD_MAX_CYC = PUD_MAX_MS * CLK_KHZ;

    // Timer width covers the longest count
    localparam int TMR_W = 22;

    // Reset cause flag positions
    localparam int CAUSE_POR_BIT = 0;
    localparam int CAUSE_BROWNOUT_BIT = 1;
    localparam logic [1:0] CAUSE_RESET = 2'h0;

    // Program memory layout
    localparam int PC_W = 24;
    localparam logic [PC_W-1:0] RESET_VECTOR = 24'h00_0000;
    localparam logic [PC_W-1:0] START_PTR_ADDR = 24'h00_0002;
    localparam logic [PC_W-1:0] IVT_BASE = 24'h00_0004;
    localparam logic [PC_W-1:0] IVT_END = 24'h00_00FF;
    localparam logic [PC_W-1:0] AIVT_BASE = 24'h00_0100;
    localparam logic [PC_W-1:0] AIVT_END = 24'h00_01FF;
    localparam logic [PC_W-1:0] VEC_REGION_END = 24'h00_0200;
    localparam logic [PC_W-1:0] PC_STEP = 24'h00_0002;

    // Sequencer states
    typedef enum logic [2:0] {
        PRS_POR_HOLD,
        PRS_POR_EXT,
        PRS_BROWNOUT_EXT,
        PRS_PUD_WAIT,
        PRS_RUN
    } prs_state_t;

    // Supply monitor flags travel together
    typedef struct packed {
        logic por_ok; // supply above power-on threshold
        logic brownout_ok; // supply above brownout_threshold
        logic clk_alive; // activity seen from monitored clock
    } prs_mon_t;

    // Reset status presented to the core
    typedef struct packed {
        logic system_reset;
        logic [1:0] cause;
        logic clk_fail;
    } prs_stat_t;

endpackage : prs_pkg

// ==== core/prs_timer.sv ====
// Down-counting delay timer for the reset sequencer.
// Assumes load and the count come from logic on clk_sys.
`timescale 1ns/1ps
module prs_timer
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load,
    input wire logic [prs_pkg::TMR_W-1:0] count,
    output logic done
);
    import prs_pkg::*;

    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] cnt_nxt;

    // Load wins; otherwise count to zero and stop
    assign cnt_nxt = load ? count : (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    assign done = (cnt_r == '0); // Count only: gating by load would loop through the sequencer

    // Counter state
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

endmodule : prs_timer

// ==== core/prs_sequencer.sv ====
// Power-on / brown-out reset sequencer with power-up delay and program counter.
// Assumes monitor flags are asynchronous comparator outputs and clk_sys is free running.
`timescale 1ns/1ps

module prs_sequencer
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire prs_pkg::prs_mon_t mon_in,
    input wire logic [2:0] power_up_delay_select,
    input wire logic [1:0] cause_clear,
    input wire logic alt_table_sel,
    input wire logic pc_advance,
    input wire logic pc_retreat,
    input wire logic pc_load,
    input wire logic [prs_pkg::PC_W-1:0] pc_target,
    input wire logic [7:0] vec_index,
    output prs_pkg::prs_stat_t stat_out,
    output logic [prs_pkg::PC_W-1:0] pc_out,
    output logic [prs_pkg::PC_W-1:0] vec_addr_out,
    output logic pc_in_vec_region
);
    import prs_pkg::*;

    // Two-flop synchronisers for the asynchronous monitor flags
    prs_mon_t mon_s1_r;
    prs_mon_t mon_s2_r;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            mon_s1_r <= '0;
            mon_s2_r <= '0;
        end
        else
        begin
            mon_s1_r <= mon_in;
            mon_s2_r <= mon_s1_r;
        end
    end

    wire por_ok = mon_s2_r.por_ok;
    wire brownout_ok = mon_s2_r.brownout_ok;

    // Power-up delay table: 0 ms, then 2,4,...,128 ms in doubling steps
    logic [TMR_W-1:0] pud_cyc;
    always_comb
    begin
        case (power_up_delay_select)
            3'h0: pud_cyc = '0;
            default: pud_cyc = TMR_W'(PUD_MAX_CYC >> (3'h7 - power_up_delay_select));
        endcase
    end

    prs_state_t state_r;
    prs_state_t state_nxt;
    logic load;
    logic [TMR_W-1:0] load_cnt;
    logic tmr_done;
    logic [1:0] cause_r;
    logic [1:0] cause_nxt;
    logic sys_rst_r;

    prs_timer u_timer
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(load),
        .count(load_cnt),
        .done(tmr_done)
    );

    // Sequencer: supply loss always pulls back to the matching hold/extension
    always_comb
    begin
        state_nxt = state_r;
        load = 1'b0;
        load_cnt = '0;
        case (state_r)
            PRS_POR_HOLD:
                if (por_ok)
                begin
                    state_nxt = PRS_POR_EXT;
                    load = 1'b1;
                    load_cnt = TMR_W'(POR_EXT_CYC);
                end
            PRS_POR_EXT, PRS_BROWNOUT_EXT, PRS_PUD_WAIT, PRS_RUN:
                if (!por_ok)
                    state_nxt = PRS_POR_HOLD;
                else if (!brownout_ok)
                begin
                    // Restarted on every dip so each recovery gets a full extension
                    state_nxt = PRS_BROWNOUT_EXT;
                    load = 1'b1;
                    load_cnt = TMR_W'(BROWNOUT_EXT_CYC);
                end
                else if (state_r != PRS_RUN && tmr_done)
                begin
                    // Extensions then power-up delay, strictly in turn
                    state_nxt = (state_r == PRS_PUD_WAIT) ? PRS_RUN : PRS_PUD_WAIT;
                    load = (state_r != PRS_PUD_WAIT);
                    load_cnt = pud_cyc;
                end
            default:
                state_nxt = PRS_POR_HOLD;
        endcase
    end

    // Cause flags: set wins over a clear in the same cycle
    assign cause_nxt = (cause_r & ~cause_clear)
        | {(state_r == PRS_BROWNOUT_EXT), 1'b0}
        | {1'b0, (state_r == PRS_POR_HOLD)};

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_r <= PRS_POR_HOLD;
            cause_r <= CAUSE_RESET;
            sys_rst_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cause_r <= cause_nxt;
            sys_rst_r <= (state_nxt != PRS_RUN);
        end
    end

    // Clock-fail monitor: alive flag must toggle within the detect window
    logic alive_d_r;
    logic [TMR_W-1:0] fscm_cnt_r;
    logic clk_fail_r;
    wire alive_edge = mon_s2_r.clk_alive ^ alive_d_r;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            alive_d_r <= 1'b0;
            fscm_cnt_r <= '0;
            clk_fail_r <= 1'b0;
        end
        else
        begin
            alive_d_r <= mon_s2_r.clk_alive;
            fscm_cnt_r <= alive_edge ? '0 : (clk_fail_r ? fscm_cnt_r : fscm_cnt_r + 1'b1);
            clk_fail_r <= !alive_edge && (fscm_cnt_r >= TMR_W'(FSCM_CYC - 1));
        end
    end

    // Program counter: reset vector, even steps, loads forced even
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    assign pc_nxt = sys_rst_r ? RESET_VECTOR
        : pc_load ? {pc_target[PC_W-1:1], 1'b0}
        : pc_advance ? pc_r + PC_STEP
        : pc_retreat ? pc_r - PC_STEP
        : pc_r;

    // Vector lookup: one even word per source in the chosen table; indices past its end share its last even word
    logic [PC_W-1:0] vec_nxt;
    assign vec_nxt = (alt_table_sel ? AIVT_BASE : IVT_BASE)
        + {15'h0000, vec_index, 1'b0};

    // Last word of the chosen table
    logic [PC_W-1:0] vec_end;
    assign vec_end = alt_table_sel ? AIVT_END : IVT_END;

    logic in_vec_r;
    logic [PC_W-1:0] vec_r;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pc_r <= RESET_VECTOR;
            vec_r <= IVT_BASE;
            in_vec_r <= 1'b1;
        end
        else
        begin
            pc_r <= pc_nxt;
            // Clamp keeps entries inside their own table, on its last even word
            vec_r <= (vec_nxt > vec_end) ? (vec_end & 24'hFF_FFFE) : vec_nxt;
            in_vec_r <= (pc_nxt < VEC_REGION_END);
        end
    end

    assign stat_out.system_reset = sys_rst_r;
    assign stat_out.cause = cause_r;
    assign stat_out.clk_fail = clk_fail_r;
    assign pc_out = pc_r;
    assign vec_addr_out = vec_r;
    assign pc_in_vec_region = in_vec_r;

    // Checks
    a_por_holds_reset: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == PRS_POR_HOLD) |=> stat_out.system_reset)
        else $error("reset released while supply below threshold");
    a_por_cause_set: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == PRS_POR_HOLD) |=> stat_out.cause[CAUSE_POR_BIT])
        else $error("power-on cause flag not set");
    a_brownout_cause_set: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == PRS_BROWNOUT_EXT) |=> stat_out.cause[CAUSE_BROWNOUT_BIT])
        else $error("brown-out cause flag not set");
    sequence s_brownout_dip;
        (state_r != PRS_POR_HOLD) && por_ok && !brownout_ok;
    endsequence
    a_brownout_restart: assert property (@(posedge clk_sys) disable iff (rst)
        s_brownout_dip |=> (state_r == PRS_BROWNOUT_EXT) ##1 stat_out.system_reset)
        else $error("brown-out did not restart extension");
    a_pc_even: assert property (@(posedge clk_sys) disable iff (rst)
        pc_out[0] == 1'b0)
        else $error("program counter odd");
    a_pc_step_two: assert property (@(posedge clk_sys) disable iff (rst)
        !sys_rst_r && !pc_load && pc_advance |=> pc_out == $past(pc_out) + PC_STEP)
        else $error("program counter did not step by two");
    a_reset_vector: assert property (@(posedge clk_sys) disable iff (rst)
        sys_rst_r |=> pc_out == RESET_VECTOR)
        else $error("fetch not at reset vector");
    a_release_order: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(sys_rst_r) |-> $past(state_r) == PRS_PUD_WAIT)
        else $error("release skipped power-up delay");
    a_vec_table: assert property (@(posedge clk_sys) disable iff (rst)
        vec_addr_out >= IVT_BASE && vec_addr_out <= AIVT_END)
        else $error("vector outside tables");
    a_fscm_bound: assert property (@(posedge clk_sys) disable iff (rst)
        (fscm_cnt_r == TMR_W'(FSCM_CYC - 1)) && !alive_edge |=> clk_fail_r)
        else $error("clock fail not flagged in time");

endmodule : prs_sequencer

// ==== tb/prs_supply_model.sv ====
// Behavioural supply monitors and monitored-clock activity source.
// Assumes the bench sets the supply levels; clk_sys is the system clock.
`timescale 1ns/1ps
module prs_supply_model
(
    input wire logic clk_sys,
    input wire logic por_lvl,
    input wire logic brownout_lvl,
    input wire logic clk_run,
    output prs_pkg::prs_mon_t mon
);
    import prs_pkg::*;
    logic [1:0] div_r = 2'h0;
    prs_mon_t mon_r = '0;
    assign mon = mon_r;
    // Activity toggles every four cycles; it freezes when the clock is lost
    always @(posedge clk_sys)
    begin
        div_r <= div_r + 2'h1;
        mon_r.por_ok <= por_lvl;
        mon_r.brownout_ok <= brownout_lvl;
        if (clk_run && div_r == 2'h3)
        begin
            mon_r.clk_alive <= ~mon_r.clk_alive;
        end
    end
endmodule : prs_supply_model

// ==== tb/tb.sv ====
// Self-checking bench for the reset sequencer.
// Assumes the supply model above and a 25 MHz clk_sys.
`timescale 1ns/1ps
module tb;
    import prs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic por_lvl = 1'b0;
    logic brownout_lvl = 1'b0;
    logic clk_run = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [1:0] clr = 2'h0;
    logic alt = 1'b0;
    logic adv = 1'b0;
    logic ret = 1'b0;
    logic ld = 1'b0;
    logic [23:0] tgt = 24'h00_0000;
    logic [7:0] vidx = 8'h00;
    prs_mon_t mon;
    prs_stat_t stat;
    logic [23:0] pc;
    logic [23:0] vec;
    logic invec;
    int n_fail = 0;
    int checks = 0;

    prs_supply_model mon_u (.clk_sys(clk_sys), .por_lvl(por_lvl), .brownout_lvl(brownout_lvl),
        .clk_run(clk_run), .mon(mon));
    prs_sequencer dut_u (.clk_sys(clk_sys), .rst(rst), .mon_in(mon),
        .power_up_delay_select(sel), .cause_clear(clr), .alt_table_sel(alt),
        .pc_advance(adv), .pc_retreat(ret), .pc_load(ld), .pc_target(tgt),
        .vec_index(vidx), .stat_out(stat), .pc_out(pc), .vec_addr_out(vec),
        .pc_in_vec_region(invec));

    // Free-running system clock
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // Counts cycles to release at falling edges, clear of the launching edge
    task automatic wait_rel(input int lo, input int hi);
        int n;
        n = 0;
        while (stat.system_reset !== 1'b0 && n < hi)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk("release_in_time", 24'(n < hi), 24'h00_0001);
        chk("release_not_early", 24'(n >= lo), 24'h00_0001);
    endtask : wait_rel

    task automatic pc_op(input logic a, input logic r, input logic l, input logic [23:0] t,
        input logic [23:0] exp, input logic exp_v);
        @(posedge clk_sys);
        adv <= a;
        ret <= r;
        ld <= l;
        tgt <= t;
        @(posedge clk_sys);
        {adv, ret, ld} <= 3'h0;
        cyc(2);
        @(negedge clk_sys);
        chk("pc", pc, exp);
        chk("in_vec", 24'(invec), 24'(exp_v));
    endtask : pc_op

    task automatic t_por;
        @(negedge clk_sys);
        chk("rst_held", 24'(stat.system_reset), 24'h00_0001);
        chk("rst_vec", vec, IVT_BASE);
        @(posedge clk_sys);
        rst <= 1'b0;
        // Fetch commands are refused while held in reset
        pc_op(1'b1, 1'b0, 1'b0, 24'h00_0000, RESET_VECTOR, 1'b1);
        chk("por_cause", 24'(stat.cause), 24'h00_0001);
        @(posedge clk_sys);
        por_lvl <= 1'b1;
        brownout_lvl <= 1'b1;
        wait_rel(750, 800);
        chk("pc_at_release", pc, RESET_VECTOR);
    endtask : t_por

    task automatic t_pc;
        pc_op(1'b1, 1'b0, 1'b0, 24'h00_0000, START_PTR_ADDR, 1'b1);
        pc_op(1'b1, 1'b1, 1'b0, 24'h00_0000, 24'h00_0004, 1'b1);
        pc_op(1'b0, 1'b1, 1'b0, 24'h00_0000, 24'h00_0002, 1'b1);
        pc_op(1'b1, 1'b0, 1'b1, 24'h00_0203, 24'h00_0202, 1'b0);
        pc_op(1'b0, 1'b0, 1'b1, 24'h00_01FE, 24'h00_01FE, 1'b1);
        pc_op(1'b1, 1'b0, 1'b0, 24'h00_0000, VEC_REGION_END, 1'b0);
    endtask : t_pc

    task automatic t_vec;
        logic [8:0] key [6] = '{9'h000, 9'h005, 9'h0FF, 9'h100, 9'h17F, 9'h1FF};
        logic [23:0] exp [6] = '{24'h00_0004, 24'h00_000E, 24'h00_00FE,
            24'h00_0100, 24'h00_01FE, 24'h00_01FE};
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk_sys);
            {alt, vidx} <= key[i];
            cyc(3);
            @(negedge clk_sys);
            chk("vec_addr", vec, exp[i]);
        end
    endtask : t_vec

    task automatic clear_cause(input logic [1:0] c);
        @(posedge clk_sys);
        clr <= c;
        @(posedge clk_sys);
        clr <= 2'h0;
        cyc(2);
        @(negedge clk_sys);
        chk("cause_cleared", 24'(stat.cause), 24'h00_0000);
    endtask : clear_cause

    // Brown-out with a 2 ms power-up delay behind its extension
    task automatic t_brownout;
        @(posedge clk_sys);
        sel <= 3'h1;
        brownout_lvl <= 1'b0;
        cyc(10);
        @(negedge clk_sys);
        chk("dip_held", 24'(stat.system_reset), 24'h00_0001);
        chk("dip_cause", 24'(stat.cause), 24'h00_0002);
        @(posedge clk_sys);
        brownout_lvl <= 1'b1;
        wait_rel(52500, 52600);
        clear_cause(2'h2);
    endtask : t_brownout

    // Longest power-up delay, cut short by a reset in mid-run
    task automatic t_rst;
        @(posedge clk_sys);
        sel <= 3'h7;
        brownout_lvl <= 1'b0;
        cyc(10);
        brownout_lvl <= 1'b1;
        cyc(3000);
        @(negedge clk_sys);
        chk("long_delay_held", 24'(stat.system_reset), 24'h00_0001);
        @(posedge clk_sys);
        rst <= 1'b1;
        sel <= 3'h0;
        cyc(2);
        rst <= 1'b0;
        @(negedge clk_sys);
        chk("rerst_held", 24'(stat.system_reset), 24'h00_0001);
        chk("rerst_cause", 24'(stat.cause), 24'h00_0000);
        chk("rerst_pc", pc, RESET_VECTOR);
        wait_rel(750, 800);
        chk("rerst_por_cause", 24'(stat.cause), 24'h00_0001);
        clear_cause(2'h1);
    endtask : t_rst

    task automatic t_fail;
        @(posedge clk_sys);
        clk_run <= 1'b0;
        cyc(20000);
        @(negedge clk_sys);
        chk("fail_early", 24'(stat.clk_fail), 24'h00_0000);
        cyc(2600);
        @(negedge clk_sys);
        chk("fail_set", 24'(stat.clk_fail), 24'h00_0001);
        @(posedge clk_sys);
        clk_run <= 1'b1;
        cyc(12);
        @(negedge clk_sys);
        chk("fail_clear", 24'(stat.clk_fail), 24'h00_0000);
    endtask : t_fail

    task automatic results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // Main sequence; reset spans two cycles
    initial
    begin
        cyc(2);
        t_por();
        clear_cause(2'h1);
        t_pc();
        t_vec();
        t_brownout();
        t_fail();
        t_rst();
        results();
    end

    // Watchdog sized above the expected run of about 80000 cycles
    initial
    begin
        #(100000 * 40);
        n_fail++;
        results();
    end
endmodule : tb
